// file: common/udc16_pkg.sv
// Package of constants, register map and types for the up/down counter channel.
package udc16_pkg;
    // Register byte offsets.
    localparam logic [11:0] ADDR_CLK_CTRL = 12'h000;
    localparam logic [11:0] ADDR_CTRL = 12'h004;
    localparam logic [11:0] ADDR_CC0 = 12'h008;
    localparam logic [11:0] ADDR_CC1 = 12'h00C;
    localparam logic [11:0] ADDR_MAX = 12'h010;
    localparam logic [11:0] ADDR_COUNT = 12'h014;
    // Clock control field positions.
    localparam int CLK_SRC_LSB = 0;
    localparam int CLK_DIV_LSB = 4;
    localparam int CLK_DEBUG_RUN_ENABLE_BIT = 8;
    // Control field positions.
    localparam int CTL_EN_BIT = 0;
    localparam int CTL_PRESET_BIT = 1;
    localparam int CTL_RUN_BIT = 2;
    localparam int CTL_DIR_LSB = 4;
    localparam int CTL_ONESHOT_BIT = 6;
    localparam int CTL_MAX_WRITE_BUSY_BIT = 8;
    localparam int CTL_RUNNING_BIT = 9;
    localparam int CTL_UPDN_BIT = 10;
    // Compare/capture control field positions.
    localparam int CC_MODE_BIT = 0;
    localparam int CC_BUF_LSB = 1;
    localparam int CC_WSRC_BIT = 4;
    localparam int CC_WMODE_LSB = 5;
    localparam int CC_WINV_BIT = 8;
    localparam int CC_SYNC_BIT = 9;
    localparam int CC_TSRC_LSB = 10;
    localparam int CC_EDGE_LSB = 12;
    // Reset values.
    localparam logic [15:0] MAX_RESET = 16'hFFFF;
    localparam logic [15:0] ZERO16 = 16'h0000;
    // Clock source codes.
    localparam logic [2:0] SRC_CORE = 3'h0;
    localparam logic [2:0] SRC_EXT = 3'h1;
    localparam logic [2:0] SRC_EXT_INV = 3'h2;
    // Direction codes.
    localparam logic [1:0] DIR_UP = 2'h0;
    localparam logic [1:0] DIR_DOWN = 2'h1;
    localparam logic [1:0] DIR_UPDN = 2'h2;
    // Counter states.
    typedef enum logic [1:0] {UDC_IDLE, UDC_UP, UDC_DOWN} udc_state_t;
endpackage

// file: rtl/udc16_core.sv
// Sixteen-bit up/down counter channel with APB register access.
//
// Overview of operation
// - Shared pin outputs wave, or captures; starts low.
// - Three-bit source and four-bit divider select.
// - Sleep clock stop halts ticks; preset still loads.
// - Debug halts counting unless debug-run set.
// - External pin counts rising, inverted counts falling.
// - Mode bit: zero compare, one capture.
// - Capture has sync, source and edge selects.
// - Wave has source, mode and invert fields.
// - Direction and one-shot give six modes.
// - Repeat runs on; one-shot stops itself.
// - Sixteen-bit maximum bounds count range.
// - Preset clears, or loads maximum when down.
// - Up count wraps to zero past maximum.
// - Run bit starts counting.
// - Counter steps on selected divided clock.
// - Running flag reads one while counting.
// - One-shot up wraps to zero and stops.
`timescale 1ns/1ps
`default_nettype none
module udc16_core (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_event_clock_pin,
    input wire logic debug_mode,
    input wire logic sleep_clock_stop,
    input wire logic [1:0] capture_trigger_in,
    input wire logic [1:0] wave_level,
    output logic [1:0] timer_wave_out_pin,
    output logic [1:0] pin_oe_n,
    output logic [15:0] current_count_value,
    output logic count_max_event,
    output logic count_zero_event
);
    import udc16_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Register state.
    logic [2:0] clock_source_select; // Count clock source.
    logic [3:0] clock_divide_select; // Division ratio exponent.
    logic debug_run_enable; // Keep counting in debug.
    logic channel_enable; // Channel enable.
    logic run_req; // Software run request.
    logic preset_tog; // Toggles on each preset write.
    logic [1:0] count_direction_mode; // Up, down or up/down.
    logic one_shot_select; // One-shot when set.
    logic [15:0] max_count_value; // Programmed maximum.
    logic max_write_busy; // Maximum transfer pending.
    logic [15:0] cc_ctrl [2]; // Compare/capture controls.
    logic [15:0] next_cc_ctrl [2];
    logic [2:0] next_src;
    logic [3:0] next_div;
    logic next_debug_run_enable, next_en, next_run_req, next_preset_tog, next_oneshot, next_busy;
    logic [1:0] next_dir;
    logic [15:0] next_max;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;
    // Counter state.
    udc_state_t state, next_state;
    logic [15:0] count, next_count;
    logic [15:0] max_live, next_max_live; // Maximum as seen by the counter.
    logic preset_seen, next_preset_seen;
    logic [14:0] div_cnt, next_div_cnt;
    logic [2:0] ext_sync, next_ext_sync; // Two-stage synchroniser plus edge history.
    logic next_max_ev, next_zero_ev;
    logic [1:0] next_wave, next_oe_n;

    // Flag decoding for the running status.
    function automatic logic is_running(input udc_state_t s);
        is_running = (s != UDC_IDLE);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Count clock tick: core clock or a synchronised pin edge, then divided.
    logic ext_rise, ext_fall, div_tick, count_tick, clock_live;
    assign ext_rise = ext_sync[1] & ~ext_sync[2];
    assign ext_fall = ~ext_sync[1] & ext_sync[2];
    // Sleep stop and debug hold suspend the count clock; divider and count stay put unless a preset loads the count.
    assign clock_live = channel_enable & ~sleep_clock_stop & (~debug_mode | debug_run_enable);
    always_comb begin
        // Selected source edge, then divided by two to the power of the divide field.
        logic src_edge;
        src_edge = 1'b0;
        if (clock_source_select == SRC_EXT) begin
            src_edge = ext_rise;
        end else if (clock_source_select == SRC_EXT_INV) begin
            src_edge = ext_fall;
        end else begin
            src_edge = 1'b1;
        end
        next_div_cnt = div_cnt;
        div_tick = 1'b0;
        if (clock_live && src_edge) begin
            if (div_cnt >= ((15'h0001 << clock_divide_select) - 15'h0001)) begin
                next_div_cnt = 15'h0000;
                div_tick = 1'b1;
            end else begin
                next_div_cnt = div_cnt + 15'h0001;
            end
        end
        count_tick = div_tick;
        next_ext_sync = {ext_sync[1:0], ext_event_clock_pin};
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave: one-wait-state answer one cycle after the access phase opens.
    always_comb begin
        next_src = clock_source_select;
        next_div = clock_divide_select;
        next_debug_run_enable = debug_run_enable;
        next_en = channel_enable;
        next_run_req = run_req;
        next_preset_tog = preset_tog;
        next_dir = count_direction_mode;
        next_oneshot = one_shot_select;
        next_max = max_count_value;
        next_busy = max_write_busy;
        next_cc_ctrl = cc_ctrl;
        next_prdata = prdata;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        // Maximum reaches the counter on the next cycle, then busy drops.
        if (max_live == max_count_value) begin
            next_busy = 1'b0;
        end
        // The counter clears the run request when a one-shot finishes.
        if (is_running(state) && next_state == UDC_IDLE) begin
            next_run_req = 1'b0;
        end
        if (psel && penable && !pready) begin
            next_pready = 1'b1;
            next_prdata = 32'h0000_0000;
            if (paddr == ADDR_CLK_CTRL) begin
                if (pwrite) begin
                    next_src = pwdata[CLK_SRC_LSB +: 3];
                    next_div = pwdata[CLK_DIV_LSB +: 4];
                    next_debug_run_enable = pwdata[CLK_DEBUG_RUN_ENABLE_BIT];
                end
                next_prdata[CLK_SRC_LSB +: 3] = clock_source_select;
                next_prdata[CLK_DIV_LSB +: 4] = clock_divide_select;
                next_prdata[CLK_DEBUG_RUN_ENABLE_BIT] = debug_run_enable;
            end else if (paddr == ADDR_CTRL) begin
                if (pwrite) begin
                    next_en = pwdata[CTL_EN_BIT];
                    next_run_req = pwdata[CTL_RUN_BIT];
                    next_dir = pwdata[CTL_DIR_LSB +: 2];
                    next_oneshot = pwdata[CTL_ONESHOT_BIT];
                    if (pwdata[CTL_PRESET_BIT]) begin
                        next_preset_tog = ~preset_tog;
                    end
                end
                next_prdata[CTL_EN_BIT] = channel_enable;
                next_prdata[CTL_RUN_BIT] = run_req;
                next_prdata[CTL_DIR_LSB +: 2] = count_direction_mode;
                next_prdata[CTL_ONESHOT_BIT] = one_shot_select;
                next_prdata[CTL_MAX_WRITE_BUSY_BIT] = max_write_busy;
                next_prdata[CTL_RUNNING_BIT] = is_running(state);
                next_prdata[CTL_UPDN_BIT] = (state == UDC_UP);
            end else if (paddr == ADDR_CC0 || paddr == ADDR_CC1) begin
                if (pwrite) begin
                    next_cc_ctrl[paddr[2]] = pwdata[15:0];
                end
                next_prdata[15:0] = cc_ctrl[paddr[2]];
            end else if (paddr == ADDR_MAX) begin
                if (pwrite) begin
                    next_max = pwdata[15:0];
                    next_busy = 1'b1;
                end
                next_prdata[15:0] = max_count_value;
            end else if (paddr == ADDR_COUNT) begin
                next_prdata[15:0] = count;
            end else begin
                next_pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            clock_source_select <= SRC_CORE;
            clock_divide_select <= 4'h0;
            debug_run_enable <= 1'b0;
            channel_enable <= 1'b0;
            run_req <= 1'b0;
            preset_tog <= 1'b0;
            count_direction_mode <= DIR_UP;
            one_shot_select <= 1'b0;
            max_count_value <= MAX_RESET;
            max_write_busy <= 1'b0;
            cc_ctrl[0] <= 16'h0000;
            cc_ctrl[1] <= 16'h0000;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            clock_source_select <= next_src;
            clock_divide_select <= next_div;
            debug_run_enable <= next_debug_run_enable;
            channel_enable <= next_en;
            run_req <= next_run_req;
            preset_tog <= next_preset_tog;
            count_direction_mode <= next_dir;
            one_shot_select <= next_oneshot;
            max_count_value <= next_max;
            max_write_busy <= next_busy;
            cc_ctrl <= next_cc_ctrl;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Counter: run and preset act one cycle after their register write.
    always_comb begin
        next_state = state;
        next_count = count;
        next_max_live = max_count_value;
        next_preset_seen = preset_seen;
        next_max_ev = 1'b0;
        next_zero_ev = 1'b0;
        if (preset_seen != preset_tog) begin
            next_preset_seen = preset_tog;
            next_count = (count_direction_mode == DIR_DOWN) ? max_live : ZERO16;
        end else if (!run_req) begin
            next_state = UDC_IDLE;
        end else if (state == UDC_IDLE) begin
            next_state = (count_direction_mode == DIR_DOWN) ? UDC_DOWN : UDC_UP;
        end else if (count_tick) begin
            if (state == UDC_UP) begin
                if (count >= max_live) begin
                    next_count = ZERO16;
                    next_max_ev = 1'b1;
                    if (count_direction_mode == DIR_UPDN) begin
                        next_count = count - 16'h0001;
                        next_state = UDC_DOWN;
                    end else if (one_shot_select) begin
                        next_state = UDC_IDLE;
                    end
                end else begin
                    next_count = count + 16'h0001;
                end
            end else begin
                if (count == ZERO16) begin
                    next_zero_ev = 1'b1;
                    if (count_direction_mode == DIR_UPDN) begin
                        next_count = count + 16'h0001;
                        next_state = one_shot_select ? UDC_IDLE : UDC_UP;
                        if (one_shot_select) begin
                            next_count = ZERO16;
                        end
                    end else begin
                        next_count = max_live;
                        next_state = one_shot_select ? UDC_IDLE : UDC_DOWN;
                    end
                end else begin
                    next_count = count - 16'h0001;
                end
            end
        end
    end

    // Pin direction: compare drives the wave level, capture releases the pin.
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            next_oe_n[i] = cc_ctrl[i][CC_MODE_BIT];
            next_wave[i] = cc_ctrl[i][CC_MODE_BIT] ? 1'b0 : (wave_level[i] ^ cc_ctrl[i][CC_WINV_BIT]);
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= UDC_IDLE;
            count <= ZERO16;
            max_live <= MAX_RESET;
            preset_seen <= 1'b0;
            div_cnt <= 15'h0000;
            ext_sync <= 3'h0;
            current_count_value <= ZERO16;
            count_max_event <= 1'b0;
            count_zero_event <= 1'b0;
            timer_wave_out_pin <= 2'h0;
            pin_oe_n <= 2'h0;
        end else begin
            state <= next_state;
            count <= next_count;
            max_live <= next_max_live;
            preset_seen <= next_preset_seen;
            div_cnt <= next_div_cnt;
            ext_sync <= next_ext_sync;
            current_count_value <= next_count;
            count_max_event <= next_max_ev;
            count_zero_event <= next_zero_ev;
            timer_wave_out_pin <= next_wave;
            pin_oe_n <= next_oe_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    sequence s_wrap_up;
        count_tick && state == UDC_UP && count >= max_live && count_direction_mode != DIR_UPDN && run_req
            && preset_seen == preset_tog;
    endsequence
    a_up_wrap_zero: assert property (@(posedge core_clk) disable iff (!arst_n)
        s_wrap_up |=> count == ZERO16) else $error("up count did not wrap to zero");
    a_oneshot_stop: assert property (@(posedge core_clk) disable iff (!arst_n)
        s_wrap_up ##0 one_shot_select |=> state == UDC_IDLE ##1 !run_req) else $error("one-shot did not stop");
    a_hold_state: assert property (@(posedge core_clk) disable iff (!arst_n)
        sleep_clock_stop && preset_seen == preset_tog |-> !count_tick ##1 $stable(count)) else $error("count ran in sleep");
    a_debug_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
        debug_mode && !debug_run_enable |-> !count_tick) else $error("count clock ran in debug");
    a_preset_load: assert property (@(posedge core_clk) disable iff (!arst_n)
        preset_seen != preset_tog |=> count == ($past(count_direction_mode) == DIR_DOWN ? $past(max_live) : ZERO16))
        else $error("preset loaded wrong value");
    a_busy_clears: assert property (@(posedge core_clk) disable iff (!arst_n)
        $rose(max_write_busy) |-> ##[1:3] !max_write_busy) else $error("max busy stuck");
    a_run_start: assert property (@(posedge core_clk) disable iff (!arst_n)
        state == UDC_IDLE && run_req && preset_seen == preset_tog |=> is_running(state)) else $error("run did not start");
    a_count_range: assert property (@(posedge core_clk) disable iff (!arst_n)
        state == UDC_UP && count_tick && count < max_live && run_req && preset_seen == preset_tog
            |=> count == $past(count) + 16'h0001) else $error("up step wrong");
    a_pin_mode: assert property (@(posedge core_clk) disable iff (!arst_n)
        ##1 pin_oe_n == {$past(cc_ctrl[1][CC_MODE_BIT]), $past(cc_ctrl[0][CC_MODE_BIT])}) else $error("pin mode wrong");
endmodule
`default_nettype wire

// file: tb/udc16_core_test.sv
// Self-checking testbench of the up/down counter channel.
`timescale 1ns/1ps
`default_nettype none
module udc16_core_test;
    import udc16_pkg::*;
    logic core_clk, arst_n, psel, penable, pwrite, debug_mode, sleep_clock_stop, ext_req;
    logic pready, pslverr, ext_pin, er, mx_seen, zr_seen;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] cap_in, wave_level, wave_req, wave_out, oe_n;
    logic [15:0] count, peak, c0;
    logic count_max_event, count_zero_event;
    int num_errors = 0;
    int comparisons = 0;
    // Capture setup for circuit 1: capture mode, sync select, trigger source 2, edge code 3.
    localparam logic [31:0] CC1_CAP = (32'h1 << CC_MODE_BIT) | (32'h1 << CC_SYNC_BIT) | (32'h2 << CC_TSRC_LSB)
        | (32'h3 << CC_EDGE_LSB);
    ////////////////////////////////////////////////////////////////////////////////
    udc16_core i_dut (.core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_event_clock_pin(ext_pin), .debug_mode(debug_mode), .sleep_clock_stop(sleep_clock_stop),
        .capture_trigger_in(cap_in), .wave_level(wave_level), .timer_wave_out_pin(wave_out),
        .pin_oe_n(oe_n), .current_count_value(count), .count_max_event(count_max_event),
        .count_zero_event(count_zero_event));
    udc16_ext_src i_src (.core_clk(core_clk), .arst_n(arst_n), .ext_level_req(ext_req), .wave_req(wave_req),
        .ext_event_clock_pin(ext_pin), .capture_trigger_in(cap_in), .wave_level(wave_level));
    // Clock of 50 ns and the signals at their idle levels from time zero.
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        {arst_n, psel, penable, pwrite, debug_mode, sleep_clock_stop, ext_req} = 7'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        wave_req = 2'b10;
    end
    // The peak value and the wrap events are tracked while a mode runs.
    always @(posedge core_clk) begin
        if (count > peak) peak <= count;
        if (count_max_event === 1'b1) mx_seen <= 1'b1;
        if (count_zero_event === 1'b1) zr_seen <= 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // One APB transfer: setup, then access held until pready is sampled high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Control word built from the field positions.
    function automatic logic [31:0] ctl(input logic [1:0] dir, input logic os, input logic pre, input logic run);
        return (32'h1 << CTL_EN_BIT) | (32'(pre) << CTL_PRESET_BIT) | (32'(run) << CTL_RUN_BIT)
            | (32'(dir) << CTL_DIR_LSB) | (32'(os) << CTL_ONESHOT_BIT);
    endfunction
    // The count port is compared with its value a fixed span earlier.
    task automatic span(input string name, input int n, input logic [15:0] step);
        c0 = count;
        repeat (n) @(posedge core_clk);
        check(name, 32'(16'(c0 + step)), 32'(count));
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        print_verdict;
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        // Reset values, and an unmapped address is refused.
        check("oe_n at reset", 32'h0, 32'(oe_n));
        check("wave at reset", 32'h0, 32'(wave_out));
        apb(1'b0, ADDR_MAX, 32'h0);
        check("max reset", 32'(MAX_RESET), rd);
        apb(1'b0, ADDR_CTRL, 32'h0);
        check("ctrl reset", 32'h0, rd);
        apb(1'b0, 12'h018, 32'h0);
        check("unmapped err", 32'h1, 32'(er));
        $display("test reset done");
        // Clock, enable, compare/capture setup and maximum come first.
        apb(1'b1, ADDR_CLK_CTRL, 32'(SRC_CORE));
        apb(1'b1, ADDR_CTRL, ctl(DIR_UP, 1'b0, 1'b0, 1'b0));
        apb(1'b1, ADDR_CC0, 32'h1 << CC_WINV_BIT);
        apb(1'b1, ADDR_CC1, CC1_CAP);
        repeat (4) @(posedge core_clk);
        check("wave out", 32'h1, 32'(wave_out));
        check("oe_n modes", 32'h2, 32'(oe_n));
        apb(1'b0, ADDR_CC1, 32'h0);
        check("cc1 fields", CC1_CAP, rd);
        apb(1'b1, ADDR_MAX, 32'h3);
        repeat (6) @(posedge core_clk);
        apb(1'b0, ADDR_CTRL, 32'h0);
        check("max busy clear", 32'h0, 32'(rd[CTL_MAX_WRITE_BUSY_BIT]));
        $display("test setup done");
        // All six modes: preset value, then run and see how counting ends.
        for (int m = 0; m < 6; m++) begin
            apb(1'b1, ADDR_CTRL, ctl(2'(m / 2), 1'(m % 2), 1'b1, 1'b0));
            repeat (4) @(posedge core_clk);
            apb(1'b0, ADDR_COUNT, 32'h0);
            check("preset value", (m / 2 == 1) ? 32'h3 : 32'h0, rd);
            {peak, mx_seen, zr_seen} <= {16'h0, 2'b00};
            apb(1'b1, ADDR_CTRL, ctl(2'(m / 2), 1'(m % 2), 1'b0, 1'b1));
            repeat (40) @(posedge core_clk);
            apb(1'b0, ADDR_CTRL, 32'h0);
            check("running flag", 32'(m % 2 == 0), 32'(rd[CTL_RUNNING_BIT]));
            check("run bit", 32'(m % 2 == 0), 32'(rd[CTL_RUN_BIT]));
            check("peak", 32'h3, 32'(peak));
            // Up counting passes the maximum, down counting reaches zero; up/down does both.
            check("wrap events", (m / 2 == 0) ? 32'h2 : ((m / 2 == 1) ? 32'h1 : 32'h3), 32'({mx_seen, zr_seen}));
            apb(1'b1, ADDR_CTRL, ctl(2'(m / 2), 1'(m % 2), 1'b0, 1'b0));
            apb(1'b0, ADDR_COUNT, 32'h0);
            if (m % 2 == 1) check("oneshot stop", (m / 2 == 1) ? 32'h3 : 32'h0, rd);
        end
        $display("test modes done");
        // Debug halt and run, sleep halt, then the divider.
        apb(1'b1, ADDR_MAX, 32'(MAX_RESET));
        apb(1'b1, ADDR_CTRL, ctl(DIR_UP, 1'b0, 1'b1, 1'b0));
        apb(1'b1, ADDR_CTRL, ctl(DIR_UP, 1'b0, 1'b0, 1'b1));
        repeat (4) @(posedge core_clk);
        span("core count", 8, 16'd8);
        debug_mode <= 1'b1;
        repeat (4) @(posedge core_clk);
        span("debug halt", 10, 16'd0);
        apb(1'b1, ADDR_CLK_CTRL, 32'h1 << CLK_DEBUG_RUN_ENABLE_BIT);
        repeat (4) @(posedge core_clk);
        span("debug run", 10, 16'd10);
        {debug_mode, sleep_clock_stop} <= 2'b01;
        repeat (4) @(posedge core_clk);
        span("sleep halt", 10, 16'd0);
        sleep_clock_stop <= 1'b0;
        repeat (4) @(posedge core_clk);
        span("sleep resume", 8, 16'd8);
        apb(1'b0, ADDR_CLK_CTRL, 32'h0);
        check("clk kept", 32'h1 << CLK_DEBUG_RUN_ENABLE_BIT, rd);
        apb(1'b1, ADDR_CLK_CTRL, 32'h1 << CLK_DIV_LSB);
        repeat (6) @(posedge core_clk);
        span("divide by two", 8, 16'd4);
        $display("test clocks done");
        // Event clock on the pin, rising then falling edges.
        for (int s = 1; s < 3; s++) begin
            apb(1'b1, ADDR_CTRL, ctl(DIR_UP, 1'b0, 1'b0, 1'b0));
            apb(1'b1, ADDR_CLK_CTRL, 32'(s));
            apb(1'b1, ADDR_CTRL, ctl(DIR_UP, 1'b0, 1'b1, 1'b1));
            // Two dummy pulses come before the edges that are measured.
            repeat (4) begin
                ext_req <= ~ext_req;
                repeat (8) @(posedge core_clk);
            end
            c0 = count;
            ext_req <= 1'b1;
            repeat (8) @(posedge core_clk);
            check("rising edge", 32'(16'(c0 + 16'(s == 1))), 32'(count));
            span("edge idle", 4, 16'd0);
            apb(1'b0, ADDR_COUNT, 32'h0);
            c0 = rd[15:0] - 16'(s == 1);
            ext_req <= 1'b0;
            repeat (8) @(posedge core_clk);
            check("falling edge", 32'(16'(c0 + 16'h1)), 32'(count));
        end
        $display("test event clock done");
        print_verdict;
    end
endmodule
`default_nettype wire

// file: tb/udc16_ext_src.sv
// Model of the event clock source and the capture and waveform pins around the counter.
`timescale 1ns/1ps
`default_nettype none
module udc16_ext_src (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic ext_level_req,
    input wire logic [1:0] wave_req,
    output logic ext_event_clock_pin,
    output logic [1:0] capture_trigger_in,
    output logic [1:0] wave_level
);
    ////////////////////////////////////////////////////////////////////////////////
    // The pin follows the requested level one cycle later, so the bench shapes every edge.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ext_event_clock_pin <= 1'b0;
            capture_trigger_in <= 2'b01;
            wave_level <= 2'b00;
        end else begin
            ext_event_clock_pin <= ext_level_req;
            // The capture lines are not watched, so they change every cycle instead of holding.
            capture_trigger_in <= ~capture_trigger_in;
            wave_level <= wave_req;
        end
    end
endmodule
`default_nettype wire
